// [include/pmi_pkg.sv]
// Purpose: Shared constants for the indirect PHY management access block
// Assumes: Byte-wide register port of the virtual EEPROM interface
// Notes: Frame timing derived from the link clock period
package pmi_pkg;
  // Register byte offsets
  localparam logic [7:0] PMI_OFF_WR_LO = 8'h70;
  localparam logic [7:0] PMI_OFF_WR_HI = 8'h71;
  localparam logic [7:0] PMI_OFF_SEL = 8'h72;
  localparam logic [7:0] PMI_OFF_IDX = 8'h73;
  localparam logic [7:0] PMI_OFF_CTRL = 8'h74;
  localparam logic [7:0] PMI_OFF_RD_LO = 8'h75;
  localparam logic [7:0] PMI_OFF_RD_HI = 8'h76;
  // Field layout
  localparam int PMI_FIELD_W = 5;
  localparam int PMI_DIR_BIT = 0;
  localparam int PMI_VALID_BIT = 1;
  localparam int PMI_FAULT_BIT = 2;
  localparam logic [7:0] PMI_ZERO_BYTE = 8'h00;
  // Frame layout
  localparam logic [31:0] PMI_PREAMBLE = 32'hffff_ffff;
  localparam logic [1:0] PMI_START = 2'h1;
  localparam logic [1:0] PMI_OP_RD = 2'h2;
  localparam logic [1:0] PMI_OP_WR = 2'h1;
  localparam logic [1:0] PMI_TA_WR = 2'h2;
  localparam logic [6:0] PMI_RD_RELEASE_BIT = 7'h2e;
  localparam logic [6:0] PMI_WR_RELEASE_BIT = 7'h40;
  localparam logic [6:0] PMI_TA_CHECK_BIT = 7'h2f;
  localparam logic [6:0] PMI_LAST_BIT = 7'h40;
  // Management clock timing
  localparam int PMI_MDC_HALF_NS = 300;
  localparam int PMI_LINK_PERIOD_NS = 125;
  localparam int PMI_MDC_HALF_CYC =
    (PMI_MDC_HALF_NS + PMI_LINK_PERIOD_NS - 1) / PMI_LINK_PERIOD_NS;
  localparam logic [2:0] PMI_PH_RISE = 3'(PMI_MDC_HALF_CYC);
  localparam logic [2:0] PMI_PH_LAST = 3'(2 * PMI_MDC_HALF_CYC - 1);
  // Link engine states
  typedef enum logic [0:0] {
    PMI_L_IDLE = 1'b0,
    PMI_L_RUN = 1'b1
  } pmi_lstate_t;
endpackage

// [verilog/pmi_sync.sv]
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Single-bit level from another clock domain
// Notes: Output changes once stages two and three agree
`timescale 1ns/1ps
module pmi_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Capture chain; first stage only feeds the second
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a change only when the last two stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= 1'b0;
    end else if (s2_q == s3_q) begin
      q <= s3_q;
    end
  end
endmodule // pmi_sync

// [verilog/pmi_reset_sync.sv]
// Purpose: Carries the core reset into the link clock domain
// Assumes: Link clock runs while the core reset is applied
// Notes: Three-flop chain with agreement filter, no reset of its own
`timescale 1ns/1ps
module pmi_reset_sync (
  input wire logic clk,
  input wire logic rst_in,
  output logic rst_out
);
  logic r1_q;
  logic r2_q;
  logic r3_q;

  // Three-stage chain; first stage only feeds the second
  always_ff @(posedge clk) begin
    r1_q <= rst_in;
    r2_q <= r1_q;
    r3_q <= r2_q;
  end

  // Follow the reset once the last two stages agree
  always_ff @(posedge clk) begin
    if (r2_q == r3_q) begin
      rst_out <= r3_q;
    end
  end
endmodule // pmi_reset_sync

// [verilog/pmi_top.sv]
// Purpose: Indirect PHY management access behind the virtual EEPROM port
// Assumes: Byte strobes arrive on clk; link_clk runs free
// Notes: Management frame engine runs on link_clk
// What this block does
// RULE1 - Access works only in virtual EEPROM mode
// RULE2 - Hold 16-bit word for PHY writes
// RULE3 - 5-bit PHY select drives frame address
// RULE4 - 5-bit register index drives frame address
// RULE5 - Control bit 0: one reads, zero writes
// RULE6 - Control byte write launches a transaction
// RULE7 - Host loads address and data before write
// RULE8 - Host writes control with bit0 clear
// RULE9 - Host loads addresses before a read
// RULE10 - Host writes control with bit0 set
// RULE11 - Control bit 2 flags management bus error
// RULE12 - Control bit 1 flags valid read word
// RULE13 - Valid flag drops when access overspeeds
// RULE14 - Returned PHY word lands in read word
// RULE15 - Host polls error before taking data
// RULE16 - Serialise standard frame with generated clock
`timescale 1ns/1ps
module pmi_top
  import pmi_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic vee_mode,
  input wire logic ee_overspeed,
  input wire logic ee_wr,
  input wire logic ee_rd,
  input wire logic [7:0] ee_addr,
  input wire logic [7:0] ee_wdata,
  output logic [7:0] ee_rdata,
  output logic ee_rvalid,
  output logic busy,
  output logic mgmt_clock_pin,
  output logic mgmt_data_out,
  output logic mgmt_data_oe,
  input wire logic mgmt_data_in
);
  // Host-visible registers
  logic [15:0] phy_write_word_q;
  logic [PMI_FIELD_W-1:0] phy_select_field_q;
  logic [PMI_FIELD_W-1:0] phy_reg_index_q;
  logic direction_code_bit_q;
  logic read_result_flag_q;
  logic mgmt_fault_flag_q;
  logic [15:0] phy_read_word_q;
  logic busy_q;

  // Launch copies, stable while a frame is in flight
  logic launch_dir_q;
  logic [PMI_FIELD_W-1:0] launch_sel_q;
  logic [PMI_FIELD_W-1:0] launch_idx_q;
  logic [15:0] launch_wdata_q;
  logic req_tgl_q;

  // Completion handshake on the core side
  logic done_s;
  logic done_seen_q;
  logic done_evt;
  logic launch;
  logic host_wr;
  logic [7:0] ctrl_byte;

  // Link-side state
  logic link_rst;
  logic req_s;
  logic req_seen_q;
  logic din_s;
  pmi_lstate_t lstate_q;
  logic [2:0] ph_q;
  logic [6:0] bit_q;
  logic [63:0] shift_q;
  logic is_rd_q;
  logic [15:0] rd_data_q;
  logic err_q;
  logic done_tgl_q;
  logic frame_end_q;
  logic frame_start;
  logic bit_end;

  // Writes only count while the port is in virtual EEPROM mode
  assign host_wr = ee_wr && vee_mode; // RULE1
  // Control byte write starts a frame unless one is running
  assign launch = host_wr && (ee_addr == PMI_OFF_CTRL) && !busy_q; // RULE6
  assign done_evt = (done_s != done_seen_q);
  assign busy = busy_q;

  // Address, index and write word loads
  always_ff @(posedge clk) begin
    if (srst) begin
      phy_write_word_q <= 16'h0000;
      phy_select_field_q <= '0;
      phy_reg_index_q <= '0;
    end else if (host_wr) begin
      unique case (ee_addr)
        PMI_OFF_WR_LO: phy_write_word_q[7:0] <= ee_wdata; // RULE2
        PMI_OFF_WR_HI: phy_write_word_q[15:8] <= ee_wdata; // RULE2
        PMI_OFF_SEL: phy_select_field_q <= ee_wdata[PMI_FIELD_W-1:0]; // RULE3
        PMI_OFF_IDX: phy_reg_index_q <= ee_wdata[PMI_FIELD_W-1:0]; // RULE4
        default: begin
        end
      endcase
    end
  end

  // Direction bit follows every accepted control byte write
  always_ff @(posedge clk) begin
    if (srst) begin
      direction_code_bit_q <= 1'b0;
    end else if (launch) begin
      direction_code_bit_q <= ee_wdata[PMI_DIR_BIT]; // RULE5
    end
  end

  // Freeze the request for the link side and flip the request toggle
  always_ff @(posedge clk) begin
    if (srst) begin
      launch_dir_q <= 1'b0;
      launch_sel_q <= '0;
      launch_idx_q <= '0;
      launch_wdata_q <= 16'h0000;
      req_tgl_q <= 1'b0;
    end else if (launch) begin
      launch_dir_q <= ee_wdata[PMI_DIR_BIT]; // RULE5
      launch_sel_q <= phy_select_field_q; // RULE3
      launch_idx_q <= phy_reg_index_q; // RULE4
      launch_wdata_q <= phy_write_word_q; // RULE2
      req_tgl_q <= ~req_tgl_q; // RULE6
    end
  end

  // Completion toggle from the link side
  pmi_sync u_done_sync (
    .clk(clk),
    .rst(srst),
    .d(done_tgl_q),
    .q(done_s)
  );

  // Remember which completion has been handled
  always_ff @(posedge clk) begin
    if (srst) begin
      done_seen_q <= 1'b0;
    end else begin
      done_seen_q <= done_s;
    end
  end

  // Busy from launch until the frame reports back
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_q <= 1'b0;
    end else if (launch) begin
      busy_q <= 1'b1;
    end else if (done_evt) begin
      busy_q <= 1'b0;
    end
  end

  // Status flags; launch and completion never coincide since busy blocks
  always_ff @(posedge clk) begin
    if (srst) begin
      read_result_flag_q <= 1'b0;
      mgmt_fault_flag_q <= 1'b0;
    end else if (done_evt) begin
      read_result_flag_q <= launch_dir_q && !err_q; // RULE12
      mgmt_fault_flag_q <= launch_dir_q && err_q; // RULE11
    end else if (launch) begin
      read_result_flag_q <= 1'b0; // RULE12
      mgmt_fault_flag_q <= 1'b0; // RULE11
    end
  end

  // Returned word; link data is quiet once the toggle has been seen
  always_ff @(posedge clk) begin
    if (srst) begin
      phy_read_word_q <= 16'h0000;
    end else if (done_evt && launch_dir_q && !err_q) begin
      phy_read_word_q <= rd_data_q; // RULE14
    end
  end

  // Control and status byte as seen by the host
  always_comb begin
    ctrl_byte = PMI_ZERO_BYTE;
    ctrl_byte[PMI_DIR_BIT] = direction_code_bit_q;
    ctrl_byte[PMI_VALID_BIT] = read_result_flag_q && !ee_overspeed; // RULE13
    ctrl_byte[PMI_FAULT_BIT] = mgmt_fault_flag_q; // RULE11
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      ee_rdata <= PMI_ZERO_BYTE;
      ee_rvalid <= 1'b0;
    end else begin
      ee_rvalid <= ee_rd;
      if (ee_rd && vee_mode) begin // RULE1
        unique case (ee_addr)
          PMI_OFF_WR_LO: ee_rdata <= phy_write_word_q[7:0];
          PMI_OFF_WR_HI: ee_rdata <= phy_write_word_q[15:8];
          PMI_OFF_SEL: ee_rdata <= 8'(phy_select_field_q);
          PMI_OFF_IDX: ee_rdata <= 8'(phy_reg_index_q);
          PMI_OFF_CTRL: ee_rdata <= ctrl_byte;
          PMI_OFF_RD_LO: ee_rdata <= phy_read_word_q[7:0]; // RULE14
          PMI_OFF_RD_HI: ee_rdata <= phy_read_word_q[15:8]; // RULE14
          default: ee_rdata <= PMI_ZERO_BYTE;
        endcase
      end else begin
        ee_rdata <= PMI_ZERO_BYTE;
      end
    end
  end

  // Link domain reset
  pmi_reset_sync u_link_rst (
    .clk(link_clk),
    .rst_in(srst),
    .rst_out(link_rst)
  );

  // Request toggle into the link domain
  pmi_sync u_req_sync (
    .clk(link_clk),
    .rst(link_rst),
    .d(req_tgl_q),
    .q(req_s)
  );

  // Data pin from the PHY
  pmi_sync u_din_sync (
    .clk(link_clk),
    .rst(link_rst),
    .d(mgmt_data_in),
    .q(din_s)
  );

  assign frame_start = (lstate_q == PMI_L_IDLE) && (req_s != req_seen_q);
  assign bit_end = (lstate_q == PMI_L_RUN) && (ph_q == PMI_PH_LAST);

  // Frame sequencer state
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lstate_q <= PMI_L_IDLE;
      req_seen_q <= 1'b0;
    end else begin
      unique case (lstate_q)
        PMI_L_IDLE: begin
          if (frame_start) begin
            req_seen_q <= req_s;
            lstate_q <= PMI_L_RUN;
          end
        end
        PMI_L_RUN: begin
          if (bit_end && (bit_q == PMI_LAST_BIT)) begin
            lstate_q <= PMI_L_IDLE;
          end
        end
      endcase
    end
  end

  // Completion waits one link cycle so the last clock high has ended
  // before the core side sees it; busy never drops with the pin high
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      frame_end_q <= 1'b0;
      done_tgl_q <= 1'b0;
    end else begin
      frame_end_q <= bit_end && (bit_q == PMI_LAST_BIT);
      if (frame_end_q) begin
        done_tgl_q <= ~done_tgl_q;
      end
    end
  end

  // Phase within a bit and bit position within the frame
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      ph_q <= 3'h0;
      bit_q <= 7'h00;
    end else if (frame_start) begin
      ph_q <= 3'h0;
      bit_q <= 7'h00;
    end else if (bit_end) begin
      ph_q <= 3'h0;
      bit_q <= bit_q + 7'h01;
    end else if (lstate_q == PMI_L_RUN) begin
      ph_q <= ph_q + 3'h1;
    end
  end

  // Build and shift out the frame, most significant bit first
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      shift_q <= 64'h0;
      is_rd_q <= 1'b0;
    end else if (frame_start) begin
      is_rd_q <= launch_dir_q; // RULE5
      shift_q <= {PMI_PREAMBLE, PMI_START,
                  launch_dir_q ? PMI_OP_RD : PMI_OP_WR,
                  launch_sel_q, launch_idx_q,
                  launch_dir_q ? 2'h0 : PMI_TA_WR,
                  launch_dir_q ? 16'h0000 : launch_wdata_q}; // RULE16
    end else if (bit_end) begin
      shift_q <= {shift_q[62:0], 1'b0};
    end
  end

  // Sample PHY answer late in the following bit to cover sync delay
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      rd_data_q <= 16'h0000;
      err_q <= 1'b0;
    end else if (frame_start) begin
      err_q <= 1'b0;
    end else if (bit_end && is_rd_q) begin
      if (bit_q == PMI_TA_CHECK_BIT) begin
        err_q <= din_s; // RULE11
      end else if ((bit_q > PMI_TA_CHECK_BIT) &&
                   (bit_q < PMI_LAST_BIT)) begin
        // Sixteen data bits follow the turnaround; the idle bit is skipped
        rd_data_q <= {rd_data_q[14:0], din_s}; // RULE14
      end
    end
  end

  // Pin drivers; clock high in the second half of each bit
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      mgmt_clock_pin <= 1'b0;
      mgmt_data_out <= 1'b1;
      mgmt_data_oe <= 1'b0;
    end else begin
      mgmt_clock_pin <= (lstate_q == PMI_L_RUN) &&
                        (ph_q >= PMI_PH_RISE); // RULE16
      mgmt_data_out <= (lstate_q == PMI_L_RUN) ? shift_q[63] : 1'b1;
      mgmt_data_oe <= (lstate_q == PMI_L_RUN) &&
                      (bit_q < (is_rd_q ? PMI_RD_RELEASE_BIT
                                        : PMI_WR_RELEASE_BIT)); // RULE16
    end
  end
endmodule // pmi_top

// [tb/pmi_chk.sv]
// Purpose: Port checks for pmi_top
// Assumes: Link side reset follows srst
// Notes: Bound below the module
`timescale 1ns/1ps
module pmi_chk
  import pmi_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic vee_mode,
  input wire logic ee_overspeed,
  input wire logic ee_wr,
  input wire logic ee_rd,
  input wire logic [7:0] ee_addr,
  input wire logic [7:0] ee_rdata,
  input wire logic ee_rvalid,
  input wire logic busy,
  input wire logic mgmt_clock_pin,
  input wire logic mgmt_data_oe
);
  // Control byte accesses
  logic ctl_wr;
  logic ctl_rd;
  assign ctl_wr = ee_wr && vee_mode && ee_addr == PMI_OFF_CTRL;
  assign ctl_rd = ee_rd && ee_addr == PMI_OFF_CTRL;
  // Launch, and one high phase of the bus clock
  sequence s_launch;
    ctl_wr && !busy;
  endsequence
  sequence s_high3;
    mgmt_clock_pin [*3] ##1 !mgmt_clock_pin;
  endsequence
  a_launch_busy: assert property (@(posedge clk) disable iff (srst)
    s_launch |=> busy [*4]) else $error("no busy");
  a_no_launch: assert property (@(posedge clk) disable iff (srst)
    !busy && !ctl_wr |=> !busy) else $error("busy rose");
  a_rvalid_rd: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> ee_rvalid == $past(ee_rd)) else $error("rvalid");
  a_mode_zero: assert property (@(posedge clk) disable iff (srst)
    ee_rd && !vee_mode |=> ee_rdata == PMI_ZERO_BYTE) else $error("rdata");
  a_speed_valid: assert property (@(posedge clk) disable iff (srst)
    ctl_rd && ee_overspeed |=> !ee_rdata[PMI_VALID_BIT]) else $error("fast");
  a_busy_valid: assert property (@(posedge clk) disable iff (srst)
    ctl_rd && busy |=> !ee_rdata[PMI_VALID_BIT]) else $error("valid");
  a_mdc_high: assert property (@(posedge link_clk) disable iff (srst)
    $rose(mgmt_clock_pin) |-> s_high3) else $error("clock high");
  a_idle_pins: assert property (@(posedge clk) disable iff (srst)
    !busy |-> !mgmt_data_oe && !mgmt_clock_pin) else $error("pins");
endmodule // pmi_chk
bind pmi_top pmi_chk u_chk (.clk, .srst, .link_clk, .vee_mode, .ee_overspeed,
  .ee_wr, .ee_rd, .ee_addr, .ee_rdata, .ee_rvalid, .busy, .mgmt_clock_pin,
  .mgmt_data_oe);

// [tb/pmi_phy_model.sv]
// Purpose: PHY model on the management bus
// Assumes: 65 clock rises a frame
// Notes: Line pull-up sits in the bench
`timescale 1ns/1ps
module pmi_phy_model (
  input wire logic link_clk,
  input wire logic srst,
  input wire logic mdc,
  input wire logic mdio,
  input wire logic err_ta,
  input wire logic [15:0] rd_word,
  output logic drv_oe,
  output logic drv_d,
  output logic [63:0] frame,
  output logic [7:0] n_frames
);
  logic mdc_q, rd_q;
  logic [6:0] cnt_q;
  logic [63:0] sh_q;
  // Sample on clock rise; answer reads after each rise
  always_ff @(posedge link_clk) begin
    mdc_q <= mdc;
    if (srst) begin
      cnt_q <= 7'h0;
      drv_oe <= 1'b0;
      n_frames <= 8'h0;
    end else if (mdc && !mdc_q) begin
      sh_q <= {sh_q[62:0], mdio};
      cnt_q <= cnt_q == 7'h40 ? 7'h0 : cnt_q + 7'h1;
      if (cnt_q == 7'h24) rd_q <= sh_q[1:0] == 2'h2;
      drv_oe <= rd_q && cnt_q > 7'h2d && cnt_q < 7'h3f;
      drv_d <= cnt_q == 7'h2e ? err_ta : rd_word[7'h3e - cnt_q];
      if (cnt_q == 7'h3f) begin
        frame <= {sh_q[62:0], mdio};
        n_frames <= n_frames + 8'h1;
      end
    end
  end
endmodule // pmi_phy_model

// [tb/pmi_top_tb.sv]
// Purpose: Self-checking bench for pmi_top
// Assumes: PHY model answers every read
// Notes: Read bytes and frames checked from queues
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module pmi_top_tb
  import pmi_pkg::*;
;
  logic clk = 0, link_clk = 0, srst = 1, vee_mode = 1, ee_overspeed = 0;
  logic ee_wr = 0, ee_rd = 0, err_ta = 0, mdio, drv_oe, drv_d, ee_rvalid;
  logic busy, mgmt_clock_pin, mgmt_data_out, mgmt_data_oe;
  logic [7:0] ee_addr = 0, ee_wdata = 0, ee_rdata, n_frames, b, e8, seen = 0;
  logic [15:0] rd_word = 0, last = 0;
  logic [63:0] frame, e64;
  logic [7:0] exp_q[$];
  logic [63:0] fq[$];
  int n_fail = 0, check_count = 0, cyc = 0;
  // Data line, pulled up when nobody drives
  assign mdio = mgmt_data_oe ? mgmt_data_out : drv_oe ? drv_d : 1'b1;
  pmi_top DUT (.clk, .srst, .link_clk, .vee_mode, .ee_overspeed, .ee_wr,
    .ee_rd, .ee_addr, .ee_wdata, .ee_rdata, .ee_rvalid, .busy,
    .mgmt_clock_pin, .mgmt_data_out, .mgmt_data_oe, .mgmt_data_in(mdio));
  pmi_phy_model u_phy (.link_clk, .srst, .mdc(mgmt_clock_pin), .mdio,
    .err_ta, .rd_word, .drv_oe, .drv_d, .frame, .n_frames);
  // Core clock and a phase-shifted link clock
  initial forever #5 clk = ~clk;
  initial #17 forever #62.5 link_clk = ~link_clk;
  // Read bytes against notes; cycle watchdog
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      summarize();
    end
    if (ee_rvalid === 1'b1) begin
      e8 = exp_q.pop_front();
      `CHK(ee_rdata, e8)
    end
  end
  // Frames seen by the PHY against notes
  always @(posedge link_clk) if (!srst && n_frames !== seen) begin
    seen = n_frames;
    e64 = fq.pop_front();
    `CHK(frame, e64)
  end
  task automatic summarize();
    `CHK(exp_q.size(), 0)
    `CHK(fq.size(), 0)
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    {ee_addr, ee_wdata, ee_wr} = {a, d, 1'b1};
    @(posedge clk) #1 ee_wr = 0;
    @(posedge clk) #1;
  endtask
  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    {ee_addr, ee_rd} = {a, 1'b1};
    @(posedge clk) #1 ee_rd = 0;
    @(posedge clk) #1;
  endtask
  // One PHY transfer with random address, data and reply
  task automatic xfer(input logic op, er);
    logic [4:0] p, r;
    logic [15:0] w;
    {p, r, w, rd_word} = 42'({$urandom(), $urandom()});
    err_ta = er;
    wr(PMI_OFF_SEL, {3'h0, p});
    wr(PMI_OFF_IDX, {3'h0, r});
    wr(PMI_OFF_WR_LO, w[7:0]);
    wr(PMI_OFF_WR_HI, w[15:8]);
    fq.push_back(op ? {PMI_PREAMBLE, PMI_START, PMI_OP_RD, p, r, 1'b1, er,
      rd_word} : {PMI_PREAMBLE, PMI_START, PMI_OP_WR, p, r, PMI_TA_WR, w});
    wr(PMI_OFF_CTRL, {7'h0, op});
    `CHK(busy, 1'b1)
    rd(PMI_OFF_CTRL, {7'h0, op});
    wr(PMI_OFF_CTRL, {7'h0, !op});
    for (int i = 0; i < 8000 && busy !== 1'b0; i++) @(posedge clk) #1;
    `CHK(busy, 1'b0)
    rd(PMI_OFF_CTRL, {5'h0, op & er, op & !er, op});
    if (op && !er) last = rd_word;
    rd(PMI_OFF_RD_LO, last[7:0]);
    rd(PMI_OFF_RD_HI, last[15:8]);
    $display("end of transfer test op=%0d err=%0d", op, er);
  endtask
  initial begin
    void'($urandom(32'h5eecdc69));
    repeat (80) @(posedge clk);
    #1 srst = 0;
    #1000;
    // Reset values and the unmapped byte
    for (int a = 'h70; a < 'h78; a++) rd(8'(a), 8'h00);
    // Mode off: writes and launches ignored
    vee_mode = 0;
    wr(PMI_OFF_SEL, 8'h1f);
    wr(PMI_OFF_CTRL, 8'h01);
    rd(PMI_OFF_SEL, 8'h00);
    `CHK(busy, 1'b0)
    vee_mode = 1;
    rd(PMI_OFF_SEL, 8'h00);
    $display("end of reset and mode test");
    // Random bytes through the field masks
    repeat (4) begin
      b = 8'($urandom());
      wr(PMI_OFF_SEL, b);
      rd(PMI_OFF_SEL, b & 8'h1f);
      wr(PMI_OFF_IDX, ~b);
      rd(PMI_OFF_IDX, ~b & 8'h1f);
    end
    `CHK(busy, 1'b0)
    $display("end of register test");
    xfer(1'b0, 1'b0);
    xfer(1'b1, 1'b0);
    ee_overspeed = 1;
    rd(PMI_OFF_CTRL, 8'h01);
    ee_overspeed = 0;
    rd(PMI_OFF_CTRL, 8'h03);
    xfer(1'b1, 1'b1);
    xfer(1'b1, 1'b0);
    xfer(1'b0, 1'b0);
    summarize();
  end
endmodule // pmi_top_tb
